/* verilog/lpc_pkg.sv */
// ==========================================================
// shared constants and types for the panel control slice
// ==========================================================
package lpc_pkg;

  // ========================================================
  // register byte addresses
  // ========================================================
  localparam logic [31:0] PATTERN_ADDR = 32'h0060_0838;
  localparam logic [31:0] POWER_ADDR = 32'h0060_083C;
  localparam logic [31:0] PWM_CTRL_ADDR = 32'h0060_0840;
  localparam logic [31:0] PWM_VALUE_ADDR = 32'h0060_0844;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h0060_0848;
  localparam logic [31:0] IRQ_DISABLE_ADDR = 32'h0060_084C;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h0060_0850;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h0060_0854;
  localparam logic [31:0] IRQ_CLEAR_ADDR = 32'h0060_0858;

  // ========================================================
  // reset values and writable field masks
  // ========================================================
  localparam logic [31:0] PATTERN_RESET = 32'h0F5F_FAFF;
  localparam logic [31:0] PATTERN_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] POWER_RESET = 32'h0000_000E;
  localparam logic [31:0] POWER_MASK = 32'h0000_00FF;
  localparam logic [31:0] PWM_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PWM_CTRL_MASK = 32'h0000_000F;
  localparam logic [31:0] PWM_VALUE_RESET = 32'h0000_0000;
  localparam logic [31:0] PWM_VALUE_MASK = 32'h0000_00FF;

  // ========================================================
  // field positions
  // ========================================================
  localparam int POWER_ON_BIT = 0;
  localparam int GUARD_LSB = 1;
  localparam int GUARD_W = 7;
  localparam int BUSY_BIT = 31;
  localparam int PS_LSB = 0;
  localparam int POL_BIT = 2;
  localparam int RUN_BIT = 3;
  localparam int CMP_W = 8;

  // event bits: line 0, last line 1, frame done 2, bit 3 unused,
  // fifo empty 4, fifo overrun 5, dma fault 6
  localparam int IRQ_W = 7;
  localparam logic [IRQ_W-1:0] IRQ_VALID = 7'h77;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] PRESCALE_ZERO = 3'h0;
  localparam logic [2:0] PRESCALE_ONE = 3'h1;

  typedef struct packed {
    logic run;
    logic pwm_output_polarity;
    logic [1:0] ps;
  } lpc_pwm_ctrl_type;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_UP,
    PWR_ON,
    PWR_DOWN
  } lpc_pwr_state_type;

endpackage

/* verilog/lpc_regs.sv */
`timescale 1ns/1ps
module lpc_regs
  import lpc_pkg::*;
#(
  parameter int GUARD_WIDTH = GUARD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_tick,
  input wire logic display_active,
  input wire logic [IRQ_W-1:0] irq_events,
  output logic [31:0] pattern_six_sevenths,
  output logic panel_power,
  output logic panel_signals_on,
  output logic contrast_out,
  output logic irq
);

  // ========================================================
  // bus slave state
  // ========================================================
  logic aw_hold, next_aw_hold;
  logic w_hold, next_w_hold;
  logic [31:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic do_write;

  // ========================================================
  // register state
  // ========================================================
  logic [31:0] pattern, next_pattern;
  logic [31:0] power_reg, next_power_reg;
  logic [31:0] pwm_ctrl_reg, next_pwm_ctrl_reg;
  logic [31:0] pwm_value_reg, next_pwm_value_reg;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [IRQ_W-1:0] irq_pending, next_irq_pending;
  logic irq_q, next_irq_q;
  lpc_pwm_ctrl_type pwm_ctrl;
  logic [GUARD_WIDTH-1:0] guard_frames;
  logic [IRQ_W-1:0] cmd_bits;

  // ========================================================
  // power sequence and contrast state
  // ========================================================
  lpc_pwr_state_type pwr_state, next_pwr_state;
  logic [GUARD_WIDTH-1:0] frame_count, next_frame_count;
  logic power_q, next_power_q;
  logic signals_q, next_signals_q;
  logic [2:0] prescale, next_prescale;
  logic [CMP_W-1:0] pwm_count, next_pwm_count;
  logic pwm_q, next_pwm_q;
  logic busy;
  logic pwm_step;

  // byte-lane merge, restricted to the implemented field bits
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb,
                                        input logic [31:0] fmask);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    m = m & fmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // handshake readies stay low while frozen so nothing is lost
  assign s_axi_awready = ce & ~aw_hold & ~bvalid;
  assign s_axi_wready = ce & ~w_hold & ~bvalid;
  assign s_axi_arready = ce & ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign do_write = aw_hold & w_hold & ~bvalid;
  assign cmd_bits = w_data[IRQ_W-1:0] & IRQ_VALID & {IRQ_W{w_strb[0]}};

  assign pwm_ctrl = lpc_pwm_ctrl_type'(pwm_ctrl_reg[3:0]);
  assign guard_frames = power_reg[GUARD_LSB +: GUARD_WIDTH];
  // busy covers both sequences and the timing generator's activity
  assign busy = display_active | (pwr_state == PWR_UP) |
                (pwr_state == PWR_DOWN);

  assign pattern_six_sevenths = pattern;
  assign panel_power = power_q;
  assign panel_signals_on = signals_q;
  assign contrast_out = pwm_q;
  assign irq = irq_q;

  // ========================================================
  // bus channels: address and data taken in either order
  // ========================================================
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_addr != PATTERN_ADDR && aw_addr != POWER_ADDR &&
          aw_addr != PWM_CTRL_ADDR && aw_addr != PWM_VALUE_ADDR &&
          aw_addr != IRQ_ENABLE_ADDR && aw_addr != IRQ_DISABLE_ADDR &&
          aw_addr != IRQ_MASK_ADDR && aw_addr != IRQ_STATUS_ADDR &&
          aw_addr != IRQ_CLEAR_ADDR) begin
        next_bresp = RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // write-only command registers read back as zero
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      if (s_axi_araddr == PATTERN_ADDR) begin
        next_rdata = pattern;
      end else if (s_axi_araddr == POWER_ADDR) begin
        next_rdata = power_reg;
        next_rdata[BUSY_BIT] = busy;
      end else if (s_axi_araddr == PWM_CTRL_ADDR) begin
        next_rdata = pwm_ctrl_reg;
      end else if (s_axi_araddr == PWM_VALUE_ADDR) begin
        next_rdata = pwm_value_reg;
      end else if (s_axi_araddr == IRQ_MASK_ADDR) begin
        next_rdata[IRQ_W-1:0] = irq_mask;
      end else if (s_axi_araddr == IRQ_STATUS_ADDR) begin
        next_rdata[IRQ_W-1:0] = irq_pending;
      end else if (s_axi_araddr == IRQ_ENABLE_ADDR ||
                   s_axi_araddr == IRQ_DISABLE_ADDR ||
                   s_axi_araddr == IRQ_CLEAR_ADDR) begin
        next_rdata = '0;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ========================================================
  // registers and interrupt bookkeeping
  // ========================================================
  always_comb begin
    next_pattern = pattern;
    next_power_reg = power_reg;
    next_pwm_ctrl_reg = pwm_ctrl_reg;
    next_pwm_value_reg = pwm_value_reg;
    next_irq_mask = irq_mask;
    next_irq_pending = irq_pending;
    if (do_write) begin
      if (aw_addr == PATTERN_ADDR) begin
        next_pattern = merge(pattern, w_data, w_strb,
                             PATTERN_MASK);
      end else if (aw_addr == POWER_ADDR) begin
        next_power_reg = merge(power_reg, w_data, w_strb,
                               POWER_MASK);
      end else if (aw_addr == PWM_CTRL_ADDR) begin
        next_pwm_ctrl_reg = merge(pwm_ctrl_reg, w_data, w_strb,
                                  PWM_CTRL_MASK);
      end else if (aw_addr == PWM_VALUE_ADDR) begin
        next_pwm_value_reg = merge(pwm_value_reg, w_data, w_strb,
                                   PWM_VALUE_MASK);
      end else if (aw_addr == IRQ_ENABLE_ADDR) begin
        next_irq_mask = irq_mask | cmd_bits;
      end else if (aw_addr == IRQ_DISABLE_ADDR) begin
        next_irq_mask = irq_mask & ~cmd_bits;
      end else if (aw_addr == IRQ_CLEAR_ADDR) begin
        next_irq_pending = irq_pending & ~cmd_bits;
      end
    end
    // a new event in the clearing cycle must survive
    next_irq_pending = next_irq_pending | (irq_events & IRQ_VALID);
    next_irq_q = |(irq_pending & irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern <= PATTERN_RESET;
      power_reg <= POWER_RESET;
      pwm_ctrl_reg <= PWM_CTRL_RESET;
      pwm_value_reg <= PWM_VALUE_RESET;
      irq_mask <= '0;
      irq_pending <= '0;
      irq_q <= 1'b0;
    end else if (ce) begin
      pattern <= next_pattern;
      power_reg <= next_power_reg;
      pwm_ctrl_reg <= next_pwm_ctrl_reg;
      pwm_value_reg <= next_pwm_value_reg;
      irq_mask <= next_irq_mask;
      irq_pending <= next_irq_pending;
      irq_q <= next_irq_q;
    end
  end

  // ========================================================
  // panel power sequencer, guard counted in frame ticks
  // ========================================================
  always_comb begin
    next_pwr_state = pwr_state;
    next_frame_count = frame_count;
    case (pwr_state)
      PWR_OFF: begin
        next_frame_count = '0;
        if (power_reg[POWER_ON_BIT]) begin
          // zero guard skips straight to powered
          next_pwr_state = (guard_frames == '0) ? PWR_ON : PWR_UP;
        end
      end
      PWR_UP: begin
        if (!power_reg[POWER_ON_BIT]) begin
          // aborted power-up still holds signals for a full guard
          next_pwr_state = PWR_DOWN;
          next_frame_count = '0;
        end else if (frame_tick) begin
          next_frame_count = frame_count + 1'b1;
          if (next_frame_count >= guard_frames) begin
            next_pwr_state = PWR_ON;
          end
        end
      end
      PWR_ON: begin
        next_frame_count = '0;
        if (!power_reg[POWER_ON_BIT]) begin
          next_pwr_state = (guard_frames == '0) ? PWR_OFF : PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (power_reg[POWER_ON_BIT]) begin
          next_pwr_state = PWR_UP;
          next_frame_count = '0;
        end else if (frame_tick) begin
          next_frame_count = frame_count + 1'b1;
          if (next_frame_count >= guard_frames) begin
            next_pwr_state = PWR_OFF;
          end
        end
      end
      default: begin
        next_pwr_state = PWR_OFF;
      end
    endcase
    next_power_q = (next_pwr_state == PWR_ON);
    next_signals_q = (next_pwr_state != PWR_OFF);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_state <= PWR_OFF;
      frame_count <= '0;
      power_q <= 1'b0;
      signals_q <= 1'b0;
    end else if (ce) begin
      pwr_state <= next_pwr_state;
      frame_count <= next_frame_count;
      power_q <= next_power_q;
      signals_q <= next_signals_q;
    end
  end

  // ========================================================
  // contrast pwm: prescaler, 8-bit wrapping counter, compare
  // ========================================================
  assign pwm_step = (prescale ==
                     3'((4'h1 << pwm_ctrl.ps) - 4'h1));

  always_comb begin
    next_prescale = prescale;
    next_pwm_count = pwm_count;
    if (pwm_ctrl.run) begin
      next_prescale = pwm_step ? PRESCALE_ZERO
                               : prescale + PRESCALE_ONE;
      if (pwm_step) begin
        next_pwm_count = pwm_count + 1'b1;
      end
    end
    // stopped generator parks at its inactive level
    if (pwm_ctrl.run) begin
      next_pwm_q = (pwm_count < pwm_value_reg[CMP_W-1:0]) ~^
                   pwm_ctrl.pwm_output_polarity;
    end else begin
      next_pwm_q = ~pwm_ctrl.pwm_output_polarity;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= PRESCALE_ZERO;
      pwm_count <= '0;
      pwm_q <= 1'b1;
    end else if (ce) begin
      prescale <= next_prescale;
      pwm_count <= next_pwm_count;
      pwm_q <= next_pwm_q;
    end
  end

endmodule

/* verif/lpc_regs_asserts.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker for the panel control slice
// ==========================================================
module lpc_regs_checker
  import lpc_pkg::*;
#(
  parameter int GUARD_WIDTH = GUARD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_tick,
  input wire logic [31:0] pattern_six_sevenths,
  input wire logic panel_power,
  input wire logic panel_signals_on,
  input wire logic irq
);
  logic seen_en;
  logic next_seen_en;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ========================================================
  // helper: enable register touched since reset
  // ========================================================
  always_comb begin
    next_seen_en = seen_en;
    if (s_axi_awvalid && s_axi_awready &&
        s_axi_awaddr == IRQ_ENABLE_ADDR) begin
      next_seen_en = 1'b1;
    end
  end
  // enables start cleared, so irq is impossible before a set
  always_ff @(posedge aclk) begin
    seen_en <= aresetn ? next_seen_en : 1'b0;
  end
  // ========================================================
  // panel sequencing
  // ========================================================
  property p_sig_first;
    panel_power |-> panel_signals_on;
  endproperty
  a_sig_first: assert property (p_sig_first)
    else $error("panel supply on without panel signals");
  property p_pwr_rise;
    $rose(panel_power) |-> $past(frame_tick) && $past(panel_signals_on);
  endproperty
  a_pwr_rise: assert property (p_pwr_rise)
    else $error("panel supply rose off a frame boundary");
  property p_pwr_drop;
    $fell(panel_power) |-> panel_signals_on;
  endproperty
  a_pwr_drop: assert property (p_pwr_drop)
    else $error("panel signals dropped with the supply");
  property p_sig_fall;
    $fell(panel_signals_on) |-> $past(frame_tick) && !$past(panel_power);
  endproperty
  a_sig_fall: assert property (p_sig_fall)
    else $error("panel signals dropped off a frame boundary");
  // ========================================================
  // registers and interrupt
  // ========================================================
  property p_pattern_width;
    (pattern_six_sevenths & ~PATTERN_MASK) == 32'h00000000;
  endproperty
  a_pattern_width: assert property (p_pattern_width)
    else $error("pattern register wider than 28 bits");
  property p_irq_needs_en;
    irq |-> seen_en;
  endproperty
  a_irq_needs_en: assert property (p_irq_needs_en)
    else $error("interrupt raised with no source enabled");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response withdrawn before taken");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data withdrawn before taken");
  property p_read_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read answer late");
  property p_ce_freeze;
    !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("ready offered while clock enable low");
endmodule

bind lpc_regs lpc_regs_checker #(.GUARD_WIDTH(GUARD_WIDTH)) lpc_regs_checker_i (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .frame_tick(frame_tick),
  .pattern_six_sevenths(pattern_six_sevenths), .panel_power(panel_power),
  .panel_signals_on(panel_signals_on), .irq(irq));

/* verif/lpc_panel_model.sv */
`timescale 1ns/1ps
// ==========================================================
// panel, frame source and contrast filter stand-in
// ==========================================================
module lpc_panel_model #(
  parameter int FRAME_CYC = 16
) (
  input wire logic aclk,
  input wire logic panel_power,
  input wire logic panel_signals_on,
  input wire logic contrast_out,
  output logic frame_tick,
  output logic [31:0] guard_ticks,
  output logic [31:0] high_cnt
);
  logic [7:0] phase;
  initial begin
    phase = 8'h00;
    frame_tick = 1'b0;
    guard_ticks = 32'h00000000;
    high_cnt = 32'h00000000;
  end
  // frames run free; ticks seen with signals up and supply off are guard
  always @(posedge aclk) begin
    phase <= (phase == 8'(FRAME_CYC - 1)) ? 8'h00 : phase + 8'h01;
    frame_tick <= (phase == 8'(FRAME_CYC - 1));
    if (frame_tick && panel_signals_on && !panel_power) begin
      guard_ticks <= guard_ticks + 32'h00000001;
    end
    // filter stand-in: integrate high time, a window gives the duty
    high_cnt <= high_cnt + {31'h00000000, contrast_out};
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import lpc_pkg::*;
  localparam logic [31:0] RST_ADDR [5] = '{PATTERN_ADDR, POWER_ADDR,
    PWM_CTRL_ADDR, PWM_VALUE_ADDR, IRQ_MASK_ADDR};
  localparam logic [31:0] RST_VAL [5] = '{PATTERN_RESET, POWER_RESET,
    PWM_CTRL_RESET, PWM_VALUE_RESET, 32'h00000000};
  localparam logic [31:0] RW_MASK [3] = '{PATTERN_MASK, POWER_MASK,
    PWM_VALUE_MASK};
  logic aclk, aresetn, ce, frame_tick, display_active, irq, p, run;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, panel_power, panel_signals_on;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] pattern_six_sevenths, guard_ticks, high_cnt, seed, rd, h0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [IRQ_W-1:0] irq_events;
  logic [7:0] v;
  logic contrast_out;
  logic [6:0] g;
  int error_cnt, compares, b, ps, k;

  lpc_regs lpc_regs_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .frame_tick(frame_tick),
    .display_active(display_active), .irq_events(irq_events),
    .pattern_six_sevenths(pattern_six_sevenths), .panel_power(panel_power),
    .panel_signals_on(panel_signals_on), .contrast_out(contrast_out),
    .irq(irq));
  lpc_panel_model lpc_panel_model_i (.aclk(aclk), .panel_power(panel_power),
    .panel_signals_on(panel_signals_on), .contrast_out(contrast_out),
    .frame_tick(frame_tick), .guard_ticks(guard_ticks), .high_cnt(high_cnt));

  // ========================================================
  // helpers
  // ========================================================
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // high cycles per filter window; a stopped counter holds the idle level
  function automatic logic [31:0] exp_highs(input logic [7:0] cv,
      input logic pl, input logic rn, input int sh);
    if (!rn) begin
      return pl ? 32'h00000000 : 32'h00000100 << sh;
    end
    return (pl ? {24'h000000, cv} : 32'h00000100 - {24'h000000, cv}) << sh;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // master holds each channel until its own ready, bready until bvalid
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [IRQ_W-1:0] e);
    @(posedge aclk);
    irq_events <= e;
    @(posedge aclk);
    irq_events <= '0;
    repeat (2) @(negedge aclk);
  endtask
  task give_verdict;
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
  // ========================================================
  // main sequence
  // ========================================================
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, display_active} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, irq_events} = '0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    seed = 32'h0E1D7B42;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("panel idle", 32'h0, {30'h0, panel_signals_on, panel_power});
    for (k = 0; k < 5; k++) begin
      axi_read(RST_ADDR[k]);
      chk("reset value", RST_VAL[k], rd);
    end
    axi_read(32'h00600860);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {rd[29:0], resp});
    // clock enable pause must not disturb stored state
    @(posedge aclk);
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    for (k = 0; k < 6; k++) begin
      seed = next_rand(seed);
      if (k > 2) seed = 32'hFFFFFFFE;
      axi_write(RST_ADDR[(k % 3) == 2 ? 3 : 0], seed);
      axi_read(RST_ADDR[(k % 3) == 2 ? 3 : 0]);
      chk("rw readback", seed & RW_MASK[(k % 3) == 2 ? 2 : 0], rd);
    end
    chk("pattern pin", 32'h0FFFFFFE, pattern_six_sevenths);
    for (b = 0; b < 7; b++) begin
      axi_write(IRQ_DISABLE_ADDR, 32'h0000007F);
      axi_write(IRQ_CLEAR_ADDR, 32'h0000007F);
      axi_write(IRQ_ENABLE_ADDR, 32'h1 << b);
      axi_write(IRQ_ENABLE_ADDR, 32'h00000000);
      axi_read(IRQ_MASK_ADDR);
      chk("mask", (32'h1 << b) & {25'h0, IRQ_VALID}, rd);
      pulse(7'h7F & ~(7'h01 << b));
      chk("irq other", 32'h00000000, {31'h0, irq});
      pulse(7'h01 << b);
      chk("irq own", {31'h0, IRQ_VALID[b]}, {31'h0, irq});
      axi_write(IRQ_DISABLE_ADDR, 32'h00000000);
      repeat (2) @(negedge aclk);
      chk("irq hold", {31'h0, IRQ_VALID[b]}, {31'h0, irq});
      axi_write(IRQ_DISABLE_ADDR, 32'h1 << b);
      repeat (2) @(negedge aclk);
      chk("irq off", 32'h00000000, {31'h0, irq});
      axi_write(IRQ_ENABLE_ADDR, 32'h1 << b);
      axi_write(IRQ_CLEAR_ADDR, 32'h1 << b);
      repeat (2) @(negedge aclk);
      chk("irq clear", 32'h00000000, {31'h0, irq});
    end
    seed = next_rand(seed);
    g = 7'd2 + {5'h00, seed[1:0]};
    axi_write(POWER_ADDR, {24'h0, g, 1'b1});
    @(negedge aclk);
    chk("power up start", 32'h2, {30'h0, panel_signals_on, panel_power});
    axi_read(POWER_ADDR);
    chk("busy up", {1'b1, 23'h0, g, 1'b1}, rd);
    for (k = 0; k < 400 && !panel_power; k++) @(negedge aclk);
    chk("up guard", {25'h0, g}, guard_ticks);
    axi_read(POWER_ADDR);
    chk("power on", {1'b0, 23'h0, g, 1'b1}, rd);
    @(posedge aclk);
    display_active <= 1'b1;
    axi_read(POWER_ADDR);
    chk("busy display", {1'b1, 23'h0, g, 1'b1}, rd);
    display_active <= 1'b0;
    axi_write(POWER_ADDR, {24'h0, g, 1'b0});
    @(negedge aclk);
    chk("power down", 32'h2, {30'h0, panel_signals_on, panel_power});
    for (k = 0; k < 400 && panel_signals_on; k++) @(negedge aclk);
    chk("down guard", {24'h0, g, 1'b0}, guard_ticks);
    chk("panel off", 32'h0, {30'h0, panel_signals_on, panel_power});
    for (ps = 0; ps < 4; ps++) begin
      for (k = 0; k < 3; k++) begin
        seed = next_rand(seed);
        v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
        p = seed[8];
        run = !(ps == 3 && k == 2);
        axi_write(PWM_VALUE_ADDR, {seed[31:8], v});
        axi_write(PWM_CTRL_ADDR, {28'h0, run, p, 2'(ps)});
        repeat ((256 << ps) + 8) @(negedge aclk);
        h0 = high_cnt;
        repeat (256 << ps) @(negedge aclk);
        chk("pwm", exp_highs(v, p, run, ps), high_cnt - h0);
      end
    end
    give_verdict();
  end
endmodule
